// [hdl/fbpe_defines.vh]
// Purpose: constants for the flash bank program/erase register block
// Assumes: 32-bit word register port, byte offsets
// Notes:   definitions only
`ifndef FBPE_DEFINES_VH
`define FBPE_DEFINES_VH
`define FBPE_OFS_ACR        8'h00
`define FBPE_OFS_KEY        8'h04
`define FBPE_OFS_OPTKEY     8'h08
`define FBPE_OFS_SR         8'h0c
`define FBPE_OFS_CR         8'h10
`define FBPE_OFS_AR         8'h14
`define FBPE_ACR_RESET      32'h00000030
`define FBPE_SR_RESET       32'h00000000
`define FBPE_CR_RESET       32'h00000080
`define FBPE_AR_RESET       32'h00000000
`define FBPE_ACR_PFE_RESET  1'b1
`define FBPE_ACR_HLF_RESET  1'b0
`define FBPE_ACR_LAT_MSB    2
`define FBPE_ACR_HLF        3
`define FBPE_ACR_PFE        4
`define FBPE_ACR_PFA        5
`define FBPE_SR_BUSY        0
`define FBPE_SR_NOT_ERASED_ERROR_FLAG       2
`define FBPE_SR_WPERR       4
`define FBPE_SR_DONE        5
`define FBPE_CR_PG          0
`define FBPE_CR_PER         1
`define FBPE_CR_MER         2
`define FBPE_CR_OPTION_PROGRAM_SELECT       4
`define FBPE_CR_OPTION_ERASE_SELECT       5
`define FBPE_CR_START_TRIGGER        6
`define FBPE_CR_LOCK        7
`define FBPE_CR_OPTION_WRITE_ENABLE      9
`define FBPE_CR_ERROR_IRQ_ENABLE       10
`define FBPE_CR_DONEIE      12
`define FBPE_KEY1_DEFAULT   32'h11112222
`define FBPE_KEY2_DEFAULT   32'h33334444
`define FBPE_ERASED_HALF    16'hffff
`define FBPE_OP_CYCLES      16'h0010
`endif

// [hdl/fbpe_key_seq.v]
// Purpose: two-word unlock key sequence detector
// Assumes: key_wr is a one-cycle strobe
// Notes:   a wrong word while armed jams the detector until reset
`timescale 1ns/1ps
module fbpe_key_seq #(
  parameter [31:0] KEY1 = 32'h11112222,
  parameter [31:0] KEY2 = 32'h33334444
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // key writes
  input  wire        key_wr,
  input  wire [31:0] key_data,
  input  wire        arm,
  // result
  output reg         unlock_pulse,
  output reg         jammed_reg
);
  reg got_first_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      got_first_reg <= 1'b0;
      jammed_reg    <= 1'b0;
      unlock_pulse  <= 1'b0;
    end else begin
      unlock_pulse <= 1'b0;
      if (key_wr && arm && !jammed_reg) begin
        if (!got_first_reg && key_data == KEY1) begin
          got_first_reg <= 1'b1;
        end else if (got_first_reg && key_data == KEY2) begin
          got_first_reg <= 1'b0;
          unlock_pulse  <= 1'b1;
        end else begin
          // stays jammed so brute force needs a reset per try
          got_first_reg <= 1'b0;
          jammed_reg    <= 1'b1;
        end
      end else if (key_wr && !arm) begin
        got_first_reg <= 1'b0;
      end
    end
  end
endmodule // fbpe_key_seq

// [hdl/fbpe_op_timer.v]
// Purpose: counts the duration of a program or erase operation
// Assumes: start is a one-cycle pulse
// Notes:   length is a parameter so simulation can shorten it
`timescale 1ns/1ps
module fbpe_op_timer #(
  parameter [15:0] CYCLES = 16'h0010
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rst_n,
  // control
  input  wire start,
  // status
  output reg  running_reg,
  output reg  finish_pulse
);
  reg [15:0] count_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_reg    <= 16'h0000;
      running_reg  <= 1'b0;
      finish_pulse <= 1'b0;
    end else begin
      finish_pulse <= 1'b0;
      if (start && !running_reg) begin
        count_reg   <= CYCLES;
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (count_reg <= 16'h0001) begin
          running_reg  <= 1'b0;
          finish_pulse <= 1'b1;
        end
        count_reg <= count_reg - 16'h0001;
      end
    end
  end
endmodule // fbpe_op_timer

// [hdl/fbpe_regs.v]
// Purpose: register file and sequencer of the flash bank program/erase
//          controller
// Assumes: word-only accesses on a plain strobe port; flash array
//          answers protection and erased-state queries combinationally
// Notes:   read data are registered and valid the cycle after rd_en
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "fbpe_defines.vh"
// Functional notes
// - all register accesses are full words
// - read/clear bits clear on written one
// - read/set bits set on written one
// - access reset 0x30, prefetch enable and status
// - access bit 3 enables half cycle
// - key registers write-only, read as zero
// - option key sequence sets option write enable
// - software may clear option write enable
// - done flag bit 5, clear by one
// - protect flag bit 4, clear by one
// - not-erased flag bit 2, clear by one
// - busy is read-only, follows the operation
// - done interrupt gated by bit 12
// - error interrupt gated by bit 10
// - lock resets set, software sets only
// - failed unlock keeps lock until reset
// - start set by software, cleared with busy
// - bits 5 and 4 select option operations
// - bits 2 and 1 select mass/page erase
// - address register, writes blocked while busy
module fbpe_regs #(
  parameter [31:0] KEY1     = `FBPE_KEY1_DEFAULT,
  parameter [31:0] KEY2     = `FBPE_KEY2_DEFAULT,
  parameter [15:0] OP_TICKS = `FBPE_OP_CYCLES
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rd_data,
  // program write from the bus into the array window
  input  wire        prog_req,
  input  wire [31:0] prog_addr,
  // flash array status
  input  wire        target_protected,
  input  wire [15:0] target_old_data,
  // flash array control
  output reg         op_start,
  output reg  [2:0]  op_kind,
  output reg  [31:0] op_addr,
  output reg         option_write_enable,
  output reg         prefetch_active,
  output reg         half_cycle_enable,
  output reg  [2:0]  wait_states,
  // interrupts
  output reg         done_irq,
  output reg         error_irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_END  = 3'b100;

  reg [2:0]  state_reg;
  reg        prefetch_enable_reg;
  reg        half_cycle_reg;
  reg [2:0]  latency_reg;
  reg        op_done_flag_reg;
  reg        protect_violation_flag_reg;
  reg        not_erased_error_flag_reg;
  reg        pg_reg;
  reg        page_erase_select_reg;
  reg        mass_erase_select_reg;
  reg        option_program_select_reg;
  reg        option_erase_select_reg;
  reg        start_trigger_reg;
  reg        lock_reg;
  reg        opt_we_reg;
  reg        error_irq_enable_reg;
  reg        done_irq_enable_reg;
  reg [31:0] target_address_reg;
  reg        launch_reg;
  reg [31:0] rd_next;

  wire op_in_progress = (state_reg != ST_IDLE);
  wire wr_acr    = wr_en && addr == `FBPE_OFS_ACR;
  wire wr_key    = wr_en && addr == `FBPE_OFS_KEY;
  wire wr_optkey = wr_en && addr == `FBPE_OFS_OPTKEY;
  wire wr_sr     = wr_en && addr == `FBPE_OFS_SR;
  wire wr_cr     = wr_en && addr == `FBPE_OFS_CR && !lock_reg;
  wire wr_cr_any = wr_en && addr == `FBPE_OFS_CR;
  wire wr_ar     = wr_en && addr == `FBPE_OFS_AR;
  wire unlock_pulse;
  wire key_jammed;
  wire opt_unlock_pulse;
  wire opt_jammed;
  wire timer_running;
  wire timer_finish;
  wire prog_go = prog_req && pg_reg && !lock_reg && !op_in_progress;

  fbpe_key_seq #(.KEY1(KEY1), .KEY2(KEY2)) u_main_key (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .key_wr       (wr_key),
    .key_data     (wr_data),
    .arm          (lock_reg),
    .unlock_pulse (unlock_pulse),
    .jammed_reg   (key_jammed)
  );

  fbpe_key_seq #(.KEY1(KEY1), .KEY2(KEY2)) u_opt_key (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .key_wr       (wr_optkey),
    .key_data     (wr_data),
    .arm          (!lock_reg),
    .unlock_pulse (opt_unlock_pulse),
    .jammed_reg   (opt_jammed)
  );

  fbpe_op_timer #(.CYCLES(OP_TICKS)) u_timer (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .start        (launch_reg),
    .running_reg  (timer_running),
    .finish_pulse (timer_finish)
  );

  // access control register
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prefetch_enable_reg <= `FBPE_ACR_PFE_RESET;
      half_cycle_reg      <= `FBPE_ACR_HLF_RESET;
      latency_reg         <= 3'h0;
    end else if (wr_acr) begin
      prefetch_enable_reg <= wr_data[`FBPE_ACR_PFE];
      half_cycle_reg      <= wr_data[`FBPE_ACR_HLF];
      latency_reg         <= wr_data[`FBPE_ACR_LAT_MSB:0];
    end
  end

  // control register and sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                  <= ST_IDLE;
      pg_reg                     <= 1'b0;
      page_erase_select_reg      <= 1'b0;
      mass_erase_select_reg      <= 1'b0;
      option_program_select_reg  <= 1'b0;
      option_erase_select_reg    <= 1'b0;
      start_trigger_reg          <= 1'b0;
      lock_reg                   <= 1'b1;
      opt_we_reg                 <= 1'b0;
      error_irq_enable_reg       <= 1'b0;
      done_irq_enable_reg        <= 1'b0;
      target_address_reg         <= `FBPE_AR_RESET;
      op_done_flag_reg           <= 1'b0;
      protect_violation_flag_reg <= 1'b0;
      not_erased_error_flag_reg  <= 1'b0;
      launch_reg                 <= 1'b0;
    end else begin
      launch_reg <= 1'b0;
      // status: clears first so a same-cycle hardware set wins
      if (wr_sr) begin
        if (wr_data[`FBPE_SR_DONE])
          op_done_flag_reg <= 1'b0;
        if (wr_data[`FBPE_SR_WPERR])
          protect_violation_flag_reg <= 1'b0;
        if (wr_data[`FBPE_SR_NOT_ERASED_ERROR_FLAG])
          not_erased_error_flag_reg <= 1'b0;
      end
      if (wr_cr_any && wr_data[`FBPE_CR_LOCK])
        lock_reg <= 1'b1;
      else if (unlock_pulse)
        lock_reg <= 1'b0;
      if (opt_unlock_pulse)
        opt_we_reg <= 1'b1;
      else if (wr_cr && !wr_data[`FBPE_CR_OPTION_WRITE_ENABLE])
        opt_we_reg <= 1'b0;
      if (wr_cr) begin
        pg_reg                    <= wr_data[`FBPE_CR_PG];
        page_erase_select_reg     <= wr_data[`FBPE_CR_PER];
        mass_erase_select_reg     <= wr_data[`FBPE_CR_MER];
        option_program_select_reg <= wr_data[`FBPE_CR_OPTION_PROGRAM_SELECT];
        option_erase_select_reg   <= wr_data[`FBPE_CR_OPTION_ERASE_SELECT];
        error_irq_enable_reg      <= wr_data[`FBPE_CR_ERROR_IRQ_ENABLE];
        done_irq_enable_reg       <= wr_data[`FBPE_CR_DONEIE];
      end
      if (wr_ar && !op_in_progress)
        target_address_reg <= wr_data;
      case (state_reg)
        ST_IDLE: begin
          if (wr_cr && wr_data[`FBPE_CR_START_TRIGGER]) begin
            start_trigger_reg <= 1'b1;
            state_reg         <= ST_BUSY;
            launch_reg        <= 1'b1;
          end else if (prog_go) begin
            target_address_reg <= prog_addr;
            if (target_protected) begin
              protect_violation_flag_reg <= 1'b1;
            end else if (target_old_data != `FBPE_ERASED_HALF) begin
              not_erased_error_flag_reg <= 1'b1;
            end else begin
              state_reg  <= ST_BUSY;
              launch_reg <= 1'b1;
            end
          end
        end
        ST_BUSY: begin
          if (timer_finish)
            state_reg <= ST_END;
        end
        ST_END: begin
          op_done_flag_reg  <= 1'b1;
          start_trigger_reg <= 1'b0;
          state_reg         <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read mux; keys always read as zero
  always @* begin
    rd_next = 32'h00000000;
    case (addr)
      `FBPE_OFS_ACR: begin
        rd_next[`FBPE_ACR_PFA]       = prefetch_active;
        rd_next[`FBPE_ACR_PFE]       = prefetch_enable_reg;
        rd_next[`FBPE_ACR_HLF]       = half_cycle_reg;
        rd_next[`FBPE_ACR_LAT_MSB:0] = latency_reg;
      end
      `FBPE_OFS_KEY: begin
        rd_next = 32'h00000000;
      end
      `FBPE_OFS_OPTKEY: begin
        rd_next = 32'h00000000;
      end
      `FBPE_OFS_SR: begin
        rd_next[`FBPE_SR_DONE]  = op_done_flag_reg;
        rd_next[`FBPE_SR_WPERR] = protect_violation_flag_reg;
        rd_next[`FBPE_SR_NOT_ERASED_ERROR_FLAG] = not_erased_error_flag_reg;
        rd_next[`FBPE_SR_BUSY]  = op_in_progress;
      end
      `FBPE_OFS_CR: begin
        rd_next[`FBPE_CR_PG]     = pg_reg;
        rd_next[`FBPE_CR_PER]    = page_erase_select_reg;
        rd_next[`FBPE_CR_MER]    = mass_erase_select_reg;
        rd_next[`FBPE_CR_OPTION_PROGRAM_SELECT]  = option_program_select_reg;
        rd_next[`FBPE_CR_OPTION_ERASE_SELECT]  = option_erase_select_reg;
        rd_next[`FBPE_CR_START_TRIGGER]   = start_trigger_reg;
        rd_next[`FBPE_CR_LOCK]   = lock_reg;
        rd_next[`FBPE_CR_OPTION_WRITE_ENABLE] = opt_we_reg;
        rd_next[`FBPE_CR_ERROR_IRQ_ENABLE]  = error_irq_enable_reg;
        rd_next[`FBPE_CR_DONEIE] = done_irq_enable_reg;
      end
      `FBPE_OFS_AR: begin
        rd_next = target_address_reg;
      end
      default: begin
        rd_next = 32'h00000000;
      end
    endcase
  end

  // registered outputs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data             <= 32'h00000000;
      op_start            <= 1'b0;
      op_kind             <= 3'h0;
      op_addr             <= 32'h00000000;
      option_write_enable <= 1'b0;
      prefetch_active     <= 1'b1;
      half_cycle_enable   <= 1'b0;
      wait_states         <= 3'h0;
      done_irq            <= 1'b0;
      error_irq           <= 1'b0;
    end else begin
      if (rd_en)
        rd_data <= rd_next;
      else
        rd_data <= 32'h00000000;
      op_start <= launch_reg;
      // kind: 0 program, 1 page, 2 mass, 3 opt program, 4 opt erase
      if (launch_reg) begin
        op_addr <= target_address_reg;
        if (option_erase_select_reg)
          op_kind <= 3'h4;
        else if (option_program_select_reg)
          op_kind <= 3'h3;
        else if (mass_erase_select_reg)
          op_kind <= 3'h2;
        else if (page_erase_select_reg)
          op_kind <= 3'h1;
        else
          op_kind <= 3'h0;
      end
      option_write_enable <= opt_we_reg;
      // prefetch switch is only taken while the array is idle
      if (!timer_running)
        prefetch_active <= prefetch_enable_reg;
      half_cycle_enable <= half_cycle_reg;
      wait_states       <= latency_reg;
      done_irq  <= done_irq_enable_reg && op_done_flag_reg;
      error_irq <= error_irq_enable_reg &&
                   (not_erased_error_flag_reg ||
                    protect_violation_flag_reg);
    end
  end
endmodule // fbpe_regs

// [verification/fbpe_checker.sv]
// Purpose: port-level assertions for fbpe_regs
// Assumes: one clock, async active-low reset
// Notes:   bound to every fbpe_regs instance
`timescale 1ns/1ps
module fbpe_checker #(
  parameter [31:0] KEY2 = 32'h0
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // register port
  input wire [7:0]  addr,
  input wire [31:0] wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data,
  // program path
  input wire        prog_req,
  input wire [31:0] prog_addr,
  // array control
  input wire        op_start,
  input wire [2:0]  op_kind,
  input wire [31:0] op_addr,
  input wire        option_write_enable,
  input wire        half_cycle_enable,
  input wire [2:0]  wait_states
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reg [31:0] last_opt_reg;
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n) last_opt_reg <= 32'h0;
    else if (wr_en && addr == 8'h08) last_opt_reg <= wr_data;
  rd_idle_zero_a: assert property (
    !$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data not zero outside a read slot");
  key_read_zero_a: assert property (
    $past(rd_en) && $past(addr) inside {8'h04, 8'h08}
    |-> rd_data == 32'h0) else $error("key register read not zero");
  acr_copy_a: assert property (
    wr_en && addr == 8'h00 |-> ##2
    half_cycle_enable == $past(wr_data[3], 2) &&
    wait_states == $past(wr_data[2:0], 2))
    else $error("access control outputs do not follow write");
  wait_cause_a: assert property (
    $changed(wait_states) |-> $past(wr_en, 2) && $past(addr, 2) == 8'h00)
    else $error("wait states changed without a write");
  opt_unlock_a: assert property (
    $rose(option_write_enable) |-> last_opt_reg == KEY2)
    else $error("option write enable rose without second key");
  start_cause_a: assert property (
    op_start |-> $past(prog_req, 2) ||
    ($past(wr_en, 2) && $past(addr, 2) == 8'h10))
    else $error("operation launched without a request");
  op_pulse_a: assert property (
    op_start |-> op_kind <= 3'h4 ##1 !op_start)
    else $error("bad operation kind or long start pulse");
  prog_addr_a: assert property (
    op_start && $past(prog_req, 2) |-> op_addr == $past(prog_addr, 2))
    else $error("program address not carried to the array");
endmodule // fbpe_checker
bind fbpe_regs fbpe_checker #(.KEY2(KEY2)) u_fbpe_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .prog_req(prog_req),
  .prog_addr(prog_addr), .op_start(op_start), .op_kind(op_kind),
  .op_addr(op_addr), .option_write_enable(option_write_enable),
  .half_cycle_enable(half_cycle_enable), .wait_states(wait_states)
);

// [verification/fbpe_flash_model.sv]
// Purpose: flash array answering protection and contents queries
// Assumes: combinational answers, as the register block expects
// Notes:   fixed map keeps expectations simple
`timescale 1ns/1ps
module fbpe_flash_model (
  // query
  input  wire [31:0] prog_addr,
  // answers
  output wire        target_protected,
  output wire [15:0] target_old_data
);
  // top 4 KB of each 64 KB window is protected
  assign target_protected = (prog_addr[15:12] == 4'hf);
  // odd half-words hold stale data so not-erased errors can be provoked
  assign target_old_data = prog_addr[1] ? 16'h1234 : 16'hffff;
endmodule // fbpe_flash_model

// [verification/testbench.sv]
// Purpose: self-checking bench for fbpe_regs
// Assumes: 25 MHz clock, operation length shortened to 4
// Notes:   far side is the flash array model
`timescale 1ns/1ps
`include "fbpe_defines.vh"
module testbench;
  typedef struct {
    logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;
  } fbpe_row_t;
  reg         clk_sys = 1'h0;
  reg         rst_n = 1'h0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wr_data = 32'h0;
  reg         wr_en = 1'h0;
  reg         rd_en = 1'h0;
  reg         prog_req = 1'h0;
  reg  [31:0] prog_addr = 32'h0;
  wire [31:0] rd_data;
  wire        target_protected;
  wire [15:0] target_old_data;
  wire        op_start;
  wire [2:0]  op_kind;
  wire        done_irq;
  wire        error_irq;
  wire        option_write_enable;
  wire        prefetch_active;
  reg  [2:0]  last_kind = 3'h0;
  reg  [31:0] got;
  integer     n_mismatch = 0;
  integer     tests_run = 0;
  integer     i;
  fbpe_row_t  rows [9];
  reg  [31:0] mode [4];
  fbpe_regs #(.OP_TICKS(16'h0004)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .prog_req(prog_req), .prog_addr(prog_addr),
    .target_protected(target_protected),
    .target_old_data(target_old_data), .op_start(op_start),
    .op_kind(op_kind), .op_addr(), .option_write_enable(option_write_enable),
    .prefetch_active(prefetch_active), .half_cycle_enable(),
    .wait_states(),
    .done_irq(done_irq), .error_irq(error_irq));
  fbpe_flash_model u_flash (.prog_addr(prog_addr),
    .target_protected(target_protected), .target_old_data(target_old_data));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (op_start) last_kind <= op_kind;
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk_sys);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk_sys);
    rd_en <= 1'h0;
    @(negedge clk_sys);
    d = rd_data;
  endtask
  task automatic chk_reg(input [7:0] a, input [31:0] e);
    rd(a, got);
    tests_run++;
    if (got !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t reg %h got %h exp %h", $time, a, got, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t pin got %b exp %b", $time, g, e);
    end
  endtask
  task automatic prog(input [31:0] a);
    @(posedge clk_sys);
    prog_req <= 1'h1;
    prog_addr <= a;
    @(posedge clk_sys);
    prog_req <= 1'h0;
  endtask
  task automatic wait_done;
    for (int k = 0; k < 60 && done_irq !== 1'h1; k++) @(posedge clk_sys);
    chk_pin(done_irq, 1'h1);
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    rows = '{'{8'h00, 1'h0, 32'h0, 32'h30}, '{8'h04, 1'h0, 32'h0, 32'h0},
      '{8'h08, 1'h0, 32'h0, 32'h0}, '{8'h0c, 1'h0, 32'h0, 32'h0},
      '{8'h10, 1'h0, 32'h0, 32'h80}, '{8'h18, 1'h1, 32'h5, 32'h0},
      '{8'h00, 1'h1, 32'h1f, 32'h3f}, '{8'h00, 1'h1, 32'h28, 32'h08},
      '{8'h10, 1'h1, 32'h1000, 32'h80}};
    mode = '{32'h2, 32'h4, 32'h10, 32'h20};
    do_reset;
    for (i = 0; i < 9; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      chk_reg(rows[i].a, rows[i].e);
    end
    chk_pin(prefetch_active, 1'h0);
    wr(8'h04, `FBPE_KEY1_DEFAULT);
    wr(8'h04, `FBPE_KEY2_DEFAULT);
    chk_reg(8'h10, 32'h0);
    wr(8'h08, `FBPE_KEY1_DEFAULT);
    wr(8'h08, `FBPE_KEY2_DEFAULT);
    chk_reg(8'h10, 32'h200);
    chk_pin(option_write_enable, 1'h1);
    // bit 9 is written as one so the option unlock survives
    for (i = 0; i < 4; i++) begin
      wr(8'h10, 32'h1640 | mode[i]);
      chk_reg(8'h0c, 32'h1);
      wait_done;
      chk_pin(last_kind == i + 1, 1'h1);
      chk_reg(8'h10, 32'h1600 | mode[i]);
      chk_reg(8'h0c, 32'h20);
      wr(8'h0c, 32'h20);
      chk_reg(8'h0c, 32'h0);
      chk_pin(done_irq, 1'h0);
    end
    wr(8'h10, 32'h1400);
    chk_reg(8'h10, 32'h1400);
    wr(8'h10, 32'h1401);
    prog(32'h0000f000);
    chk_reg(8'h0c, 32'h10);
    chk_pin(error_irq, 1'h1);
    wr(8'h0c, 32'h0);
    chk_reg(8'h0c, 32'h10);
    wr(8'h0c, 32'h10);
    prog(32'h00000002);
    chk_reg(8'h0c, 32'h04);
    wr(8'h0c, 32'h04);
    prog(32'h00000100);
    wr(8'h14, 32'habc0);
    wait_done;
    chk_reg(8'h14, 32'h100);
    chk_reg(8'h0c, 32'h20);
    chk_pin(error_irq, 1'h0);
    wr(8'h0c, 32'h20);
    wr(8'h10, 32'h0442);
    got = 32'h0;
    for (i = 0; i < 20 && got !== 32'h20; i++) rd(8'h0c, got);
    chk_reg(8'h0c, 32'h20);
    chk_pin(done_irq, 1'h0);
    wr(8'h10, 32'h80);
    chk_reg(8'h10, 32'h80);
    wr(8'h04, 32'h0);
    wr(8'h04, `FBPE_KEY1_DEFAULT);
    wr(8'h04, `FBPE_KEY2_DEFAULT);
    chk_reg(8'h10, 32'h80);
    do_reset;
    chk_reg(8'h00, 32'h30);
    chk_pin(prefetch_active, 1'h1);
    wr(8'h04, `FBPE_KEY1_DEFAULT);
    wr(8'h04, `FBPE_KEY2_DEFAULT);
    chk_reg(8'h10, 32'h0);
    report_and_stop;
  end
endmodule // testbench
